// ===== core/amd_decoder.sv
// Instruction fetch and addressing-mode decoder for an 8-bit core.
// Assumes a synchronous byte memory: mem_rdata holds the byte two cycles after mem_rd_ff rises.
//
// Behaviour
// RULE1: seventeen modes in seven classes.
// RULE2: long forms reach full 64 Kbyte space.
// RULE3: short forms address page zero, fewer bytes; short indexed forms add with carry and reach up to 01FE.
// RULE4: read-modify-write opcodes decode short forms only.
// RULE5: inherent instructions are one byte.
// RULE6: immediate is opcode plus operand byte.
// RULE7: direct address follows opcode, operand there.
// RULE8: set-mask instruction raises mask to three.
// RULE9: clear-mask instruction lowers mask to zero.
// RULE10: wait instruction sleeps until interrupt.
// RULE11: halt stops oscillator, lowest power.
// RULE12: push/pop one byte, adjust stack pointer.
// RULE13: test and shifts exist as inherent forms.
// RULE14: indexed address is unsigned index plus offset.
// RULE15: relative target adds signed 8-bit offset.
// RULE16: prefix 90 selects second index register.
// RULE17: prefix 92 turns direct into indirect.
// RULE18: long pointer fetched from page zero, high first.
// RULE19: length from opcode, mode and prefix.
`default_nettype none
module amd_decoder #(
  parameter logic [15:0] RESET_PC = amd_pkg::PC_RESET
) (
  // Clock and reset.
  input  wire logic        clk_sys,
  input  wire logic        reset,
  // Memory read port.
  output logic [15:0]      mem_addr_ff,
  output logic             mem_rd_ff,
  input  wire logic [7:0]  mem_rdata,
  // Core register and execution handshake.
  input  wire logic [7:0]  index_x,
  input  wire logic [7:0]  index_y,
  input  wire logic        exec_done,
  input  wire logic        pc_load,
  input  wire logic [15:0] pc_load_addr,
  input  wire logic        irq_req,
  input  wire logic        wake_pin,
  // Decoded instruction.
  output logic             dec_valid_ff,
  output logic [7:0]       dec_opcode_ff,
  output amd_pkg::amd_mode_t  dec_mode_ff,
  output amd_pkg::amd_group_t dec_group_ff,
  output logic [2:0]       dec_len_ff,
  output logic [7:0]       dec_operand_ff,
  output logic [15:0]      dec_ea_ff,
  output logic [15:0]      dec_target_ff,
  output logic [15:0]      dec_next_pc_ff,
  output logic             dec_use_y_ff,
  // Core control state.
  output logic [1:0]       irq_mask_ff,
  output logic             wait_ff,
  output logic             osc_stop_ff,
  output logic             stack_push_ff,
  output logic             stack_pop_ff,
  output logic [15:0]      sp_ff
);

  typedef enum logic [2:0] {
    S_OPC, S_ARG, S_PTR, S_DONE, S_EXEC, S_WAIT, S_HALT
  } amd_state_t;

  amd_state_t         state_ff;
  amd_pkg::amd_mode_t mode_ff;
  logic [1:0]  phase_ff;
  logic [15:0] pc_ff;
  logic [7:0]  opc_ff;
  logic        pfx_ff;
  logic        use_y_ff;
  logic        ind_ff;
  logic [1:0]  arg_idx_ff;
  logic [1:0]  n_arg_ff;
  logic [7:0]  arg_ff [0:1];
  logic [1:0]  ptr_idx_ff;
  logic [1:0]  n_ptr_ff;
  logic [7:0]  ptr_ff [0:1];
  logic        wake_s1_ff;
  logic        wake_s2_ff;
  logic        wake_s3_ff;
  logic        wake_ff;

  ////////////////////////////////////////////////////////////////////////////
  // Decode tables.

  function automatic amd_pkg::amd_mode_t mode_of(input logic [3:0] hi, input logic ind);
    amd_pkg::amd_mode_t m;
    m = amd_pkg::M_INH;
    case (hi)
      amd_pkg::NIB_BIT_REL: m = ind ? amd_pkg::M_BITR_I : amd_pkg::M_BITR_D; // [RULE17]
      amd_pkg::NIB_BIT:     m = ind ? amd_pkg::M_BIT_I  : amd_pkg::M_BIT_D;
      amd_pkg::NIB_REL:     m = ind ? amd_pkg::M_REL_I  : amd_pkg::M_REL_D;
      // Read-modify-write nibbles have no long encodings at all.
      amd_pkg::NIB_RMW_DIR,
      amd_pkg::NIB_DIR:     m = ind ? amd_pkg::M_IND_S  : amd_pkg::M_DIR_S; // [RULE4] [RULE3]
      amd_pkg::NIB_EXT:     m = ind ? amd_pkg::M_IND_L  : amd_pkg::M_DIR_L; // [RULE2]
      amd_pkg::NIB_IX2:     m = ind ? amd_pkg::M_INDX_L : amd_pkg::M_IDX_L;
      amd_pkg::NIB_RMW_IX1,
      amd_pkg::NIB_IX1:     m = ind ? amd_pkg::M_INDX_S : amd_pkg::M_IDX_S; // [RULE4]
      amd_pkg::NIB_RMW_IX0,
      amd_pkg::NIB_IX0:     m = amd_pkg::M_IDX_0;
      amd_pkg::NIB_IMM:     m = amd_pkg::M_IMM; // [RULE6]
      // Accumulator and index tests, shifts and misc control are inherent.
      default:              m = amd_pkg::M_INH; // [RULE13] [RULE5]
    endcase
    return m; // [RULE1]
  endfunction

  function automatic amd_pkg::amd_group_t group_of(input amd_pkg::amd_mode_t m);
    case (m)
      amd_pkg::M_INH:   return amd_pkg::G_INHERENT;
      amd_pkg::M_IMM:   return amd_pkg::G_IMMEDIATE;
      amd_pkg::M_DIR_S, amd_pkg::M_DIR_L: return amd_pkg::G_DIRECT;
      amd_pkg::M_IDX_0, amd_pkg::M_IDX_S, amd_pkg::M_IDX_L: return amd_pkg::G_INDEXED;
      amd_pkg::M_IND_S, amd_pkg::M_IND_L, amd_pkg::M_INDX_S,
      amd_pkg::M_INDX_L: return amd_pkg::G_INDIRECT;
      amd_pkg::M_REL_D, amd_pkg::M_REL_I: return amd_pkg::G_RELATIVE;
      default:          return amd_pkg::G_BIT;
    endcase
  endfunction

  // Bytes after the opcode.
  function automatic logic [1:0] args_of(input amd_pkg::amd_mode_t m);
    case (m)
      amd_pkg::M_INH, amd_pkg::M_IDX_0: return amd_pkg::LEN_NONE; // [RULE5]
      amd_pkg::M_DIR_L, amd_pkg::M_IDX_L,
      amd_pkg::M_BITR_D, amd_pkg::M_BITR_I: return amd_pkg::LEN_WORD;
      default: return amd_pkg::LEN_BYTE; // [RULE6] [RULE7]
    endcase
  endfunction

  // Bytes read through a page-zero pointer.
  function automatic logic [1:0] ptrs_of(input amd_pkg::amd_mode_t m);
    case (m)
      amd_pkg::M_IND_L, amd_pkg::M_INDX_L: return amd_pkg::LEN_WORD; // [RULE18]
      amd_pkg::M_IND_S, amd_pkg::M_INDX_S, amd_pkg::M_REL_I,
      amd_pkg::M_BIT_I, amd_pkg::M_BITR_I: return amd_pkg::LEN_BYTE;
      default: return amd_pkg::LEN_NONE;
    endcase
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // Address arithmetic.

  logic [7:0]  idx_sel;
  logic [15:0] ea;
  logic [7:0]  rel_ofs;
  logic [15:0] target;
  logic [2:0]  len;

  always_comb begin
    idx_sel = use_y_ff ? index_y : index_x; // [RULE16]
    rel_ofs = arg_ff[0];
    case (mode_ff)
      amd_pkg::M_DIR_S, amd_pkg::M_BIT_D, amd_pkg::M_BITR_D:
        ea = {amd_pkg::PAGE_ZERO_HI, arg_ff[0]}; // [RULE3] [RULE7]
      amd_pkg::M_DIR_L:  ea = {arg_ff[0], arg_ff[1]}; // [RULE2] [RULE7]
      amd_pkg::M_IDX_0:  ea = {amd_pkg::PAGE_ZERO_HI, idx_sel};
      amd_pkg::M_IDX_S:  ea = {amd_pkg::PAGE_ZERO_HI, idx_sel} + {8'h00, arg_ff[0]}; // [RULE14]
      amd_pkg::M_IDX_L:  ea = {arg_ff[0], arg_ff[1]} + {8'h00, idx_sel}; // [RULE14]
      amd_pkg::M_IND_S, amd_pkg::M_BIT_I, amd_pkg::M_BITR_I:
        ea = {amd_pkg::PAGE_ZERO_HI, ptr_ff[0]};
      amd_pkg::M_IND_L:  ea = {ptr_ff[0], ptr_ff[1]}; // [RULE18]
      amd_pkg::M_INDX_S: ea = {amd_pkg::PAGE_ZERO_HI, idx_sel} + {8'h00, ptr_ff[0]}; // [RULE14]
      amd_pkg::M_INDX_L: ea = {ptr_ff[0], ptr_ff[1]} + {8'h00, idx_sel};
      default:           ea = pc_ff;
    endcase
    case (mode_ff)
      amd_pkg::M_REL_I:  rel_ofs = ptr_ff[0];
      amd_pkg::M_BITR_D, amd_pkg::M_BITR_I: rel_ofs = arg_ff[1];
      default:           rel_ofs = arg_ff[0];
    endcase
    target = pc_ff + {{8{rel_ofs[7]}}, rel_ofs}; // [RULE15]
    len = 3'(pfx_ff) + amd_pkg::OPC_LEN + 3'(n_arg_ff); // [RULE19]
  end

  ////////////////////////////////////////////////////////////////////////////
  // Wake pin synchroniser; a level counts once the last two stages agree.

  always_ff @(posedge clk_sys) begin
    wake_s1_ff <= wake_pin;
    wake_s2_ff <= wake_s1_ff;
    wake_s3_ff <= wake_s2_ff;
    if (reset) begin
      wake_ff <= 1'b0;
    end else if (wake_s2_ff == wake_s3_ff) begin
      wake_ff <= wake_s3_ff;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Fetch sequencer and memory reads.

  always_ff @(posedge clk_sys) begin
    if (reset) begin
      state_ff    <= S_OPC;
      phase_ff    <= amd_pkg::PH_ISSUE;
      pc_ff       <= RESET_PC;
      mem_addr_ff <= amd_pkg::PC_RESET;
      mem_rd_ff   <= 1'b0;
      opc_ff      <= 8'h00;
      mode_ff     <= amd_pkg::M_INH;
      pfx_ff      <= 1'b0;
      use_y_ff    <= 1'b0;
      ind_ff      <= 1'b0;
      arg_idx_ff  <= amd_pkg::LEN_NONE;
      n_arg_ff    <= amd_pkg::LEN_NONE;
      ptr_idx_ff  <= amd_pkg::LEN_NONE;
      n_ptr_ff    <= amd_pkg::LEN_NONE;
      arg_ff[0]   <= 8'h00;
      arg_ff[1]   <= 8'h00;
      ptr_ff[0]   <= 8'h00;
      ptr_ff[1]   <= 8'h00;
    end else begin
      mem_rd_ff <= 1'b0;
      case (state_ff)
        S_OPC, S_ARG, S_PTR: begin
          case (phase_ff)
            amd_pkg::PH_ISSUE: begin
              mem_rd_ff <= 1'b1;
              phase_ff  <= amd_pkg::PH_WAIT;
              // Pointers live in page zero, high byte at the lower address.
              mem_addr_ff <= (state_ff == S_PTR) ?
                {amd_pkg::PAGE_ZERO_HI, arg_ff[0] + {6'h00, ptr_idx_ff}} : pc_ff; // [RULE18]
            end
            amd_pkg::PH_WAIT: phase_ff <= amd_pkg::PH_TAKE;
            default: begin
              phase_ff <= amd_pkg::PH_ISSUE;
              if (state_ff != S_PTR) begin
                pc_ff <= pc_ff + 16'h0001;
              end
              if (state_ff == S_OPC) begin
                if (!pfx_ff && mem_rdata == amd_pkg::SECOND_INDEX_PREFIX) begin
                  pfx_ff   <= 1'b1;
                  use_y_ff <= 1'b1; // [RULE16]
                end else if (!pfx_ff && mem_rdata == amd_pkg::INDIRECT_PREFIX) begin
                  pfx_ff <= 1'b1;
                  ind_ff <= 1'b1; // [RULE17]
                end else begin
                  opc_ff     <= mem_rdata;
                  mode_ff    <= mode_of(mem_rdata[7:4], ind_ff);
                  n_arg_ff   <= args_of(mode_of(mem_rdata[7:4], ind_ff)); // [RULE19]
                  n_ptr_ff   <= ptrs_of(mode_of(mem_rdata[7:4], ind_ff));
                  arg_idx_ff <= amd_pkg::LEN_NONE;
                  ptr_idx_ff <= amd_pkg::LEN_NONE;
                  state_ff   <= (args_of(mode_of(mem_rdata[7:4], ind_ff)) ==
                                 amd_pkg::LEN_NONE) ? S_DONE : S_ARG;
                end
              end else if (state_ff == S_ARG) begin
                arg_ff[arg_idx_ff[0]] <= mem_rdata;
                arg_idx_ff <= arg_idx_ff + 2'h1;
                if (arg_idx_ff + 2'h1 == n_arg_ff) begin
                  state_ff <= (n_ptr_ff == amd_pkg::LEN_NONE) ? S_DONE : S_PTR;
                end
              end else begin
                ptr_ff[ptr_idx_ff[0]] <= mem_rdata;
                ptr_idx_ff <= ptr_idx_ff + 2'h1;
                if (ptr_idx_ff + 2'h1 == n_ptr_ff) begin
                  state_ff <= S_DONE;
                end
              end
            end
          endcase
        end
        S_DONE: begin
          if (opc_ff == amd_pkg::WAIT_IRQ_OP && mode_ff == amd_pkg::M_INH) begin
            state_ff <= S_WAIT; // [RULE10]
          end else if (opc_ff == amd_pkg::HALT_OP && mode_ff == amd_pkg::M_INH) begin
            state_ff <= S_HALT; // [RULE11]
          end else begin
            state_ff <= S_EXEC;
          end
        end
        S_EXEC: begin
          if (exec_done) begin
            state_ff <= S_OPC;
            pfx_ff   <= 1'b0;
            use_y_ff <= 1'b0;
            ind_ff   <= 1'b0;
            if (pc_load) begin
              pc_ff <= pc_load_addr;
            end
          end
        end
        S_WAIT: begin
          if (irq_req) begin
            state_ff <= S_EXEC; // [RULE10]
          end
        end
        S_HALT: begin
          if (wake_ff) begin
            state_ff <= S_EXEC; // [RULE11]
          end
        end
        default: state_ff <= S_OPC;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Decoded instruction outputs.

  always_ff @(posedge clk_sys) begin
    if (reset) begin
      dec_valid_ff   <= 1'b0;
      dec_opcode_ff  <= 8'h00;
      dec_mode_ff    <= amd_pkg::M_INH;
      dec_group_ff   <= amd_pkg::G_INHERENT;
      dec_len_ff     <= 3'h0;
      dec_operand_ff <= 8'h00;
      dec_ea_ff      <= 16'h0000;
      dec_target_ff  <= 16'h0000;
      dec_next_pc_ff <= 16'h0000;
      dec_use_y_ff   <= 1'b0;
    end else begin
      dec_valid_ff <= (state_ff == S_DONE);
      if (state_ff == S_DONE) begin
        dec_opcode_ff  <= opc_ff;
        dec_mode_ff    <= mode_ff;
        dec_group_ff   <= group_of(mode_ff); // [RULE1]
        dec_len_ff     <= len; // [RULE19]
        dec_operand_ff <= arg_ff[0]; // [RULE6]
        dec_ea_ff      <= ea;
        dec_target_ff  <= target; // [RULE15]
        dec_next_pc_ff <= pc_ff;
        dec_use_y_ff   <= use_y_ff;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Inherent control: interrupt mask, low power and stack.

  logic inh_done;
  assign inh_done = (state_ff == S_DONE) && (mode_ff == amd_pkg::M_INH);

  always_ff @(posedge clk_sys) begin
    if (reset) begin
      irq_mask_ff <= amd_pkg::IRQ_LEVEL_MASK;
    end else if (inh_done && opc_ff == amd_pkg::SET_IRQ_MASK_OP) begin
      irq_mask_ff <= amd_pkg::IRQ_LEVEL_MASK; // [RULE8]
    end else if (inh_done && opc_ff == amd_pkg::CLEAR_IRQ_MASK_OP) begin
      irq_mask_ff <= amd_pkg::IRQ_LEVEL_ALL; // [RULE9]
    end
  end

  always_ff @(posedge clk_sys) begin
    if (reset) begin
      wait_ff     <= 1'b0;
      osc_stop_ff <= 1'b0;
    end else begin
      wait_ff     <= (inh_done && opc_ff == amd_pkg::WAIT_IRQ_OP) ||
                     (state_ff == S_WAIT && !irq_req); // [RULE10]
      osc_stop_ff <= (inh_done && opc_ff == amd_pkg::HALT_OP) ||
                     (state_ff == S_HALT && !wake_ff); // [RULE11]
    end
  end

  always_ff @(posedge clk_sys) begin
    if (reset) begin
      stack_push_ff <= 1'b0;
      stack_pop_ff  <= 1'b0;
      sp_ff         <= amd_pkg::SP_RESET;
    end else begin
      stack_push_ff <= inh_done && opc_ff == amd_pkg::PUSH_OP; // [RULE12]
      stack_pop_ff  <= inh_done && opc_ff == amd_pkg::POP_OP;
      if (inh_done && opc_ff == amd_pkg::PUSH_OP) begin
        sp_ff <= sp_ff - 16'h0001; // [RULE12]
      end else if (inh_done && opc_ff == amd_pkg::POP_OP) begin
        sp_ff <= sp_ff + 16'h0001;
      end else if (inh_done && opc_ff == amd_pkg::STACK_RESET_OP) begin
        sp_ff <= amd_pkg::SP_RESET;
      end
    end
  end

endmodule
`default_nettype wire

// ===== core/amd_pkg.sv
// Constants and types shared by the addressing-mode decoder.
// Assumes a byte-wide program/data memory and a 16-bit address space.
`default_nettype none
package amd_pkg;
  localparam int          ADDR_W       = 16;
  localparam logic [15:0] PC_RESET     = 16'h0000;
  localparam logic [15:0] SP_RESET     = 16'h01FF;
  localparam logic [7:0]  PAGE_ZERO_HI = 8'h00;
  // Prefix bytes.
  localparam logic [7:0]  SECOND_INDEX_PREFIX = 8'h90;
  localparam logic [7:0]  INDIRECT_PREFIX     = 8'h92;
  // Inherent control opcodes.
  localparam logic [7:0]  SET_IRQ_MASK_OP   = 8'h9B;
  localparam logic [7:0]  CLEAR_IRQ_MASK_OP = 8'h9A;
  localparam logic [7:0]  WAIT_IRQ_OP       = 8'h8F;
  localparam logic [7:0]  HALT_OP           = 8'h8E;
  localparam logic [7:0]  PUSH_OP           = 8'h88;
  localparam logic [7:0]  POP_OP            = 8'h84;
  localparam logic [7:0]  STACK_RESET_OP    = 8'h9C;
  // Opcode high nibbles that select the addressing form.
  localparam logic [3:0]  NIB_BIT_REL = 4'h0;
  localparam logic [3:0]  NIB_BIT     = 4'h1;
  localparam logic [3:0]  NIB_REL     = 4'h2;
  localparam logic [3:0]  NIB_RMW_DIR = 4'h3;
  localparam logic [3:0]  NIB_RMW_IX1 = 4'h6;
  localparam logic [3:0]  NIB_RMW_IX0 = 4'h7;
  localparam logic [3:0]  NIB_IMM     = 4'hA;
  localparam logic [3:0]  NIB_DIR     = 4'hB;
  localparam logic [3:0]  NIB_EXT     = 4'hC;
  localparam logic [3:0]  NIB_IX2     = 4'hD;
  localparam logic [3:0]  NIB_IX1     = 4'hE;
  localparam logic [3:0]  NIB_IX0     = 4'hF;
  // Interrupt mask levels.
  localparam logic [1:0]  IRQ_LEVEL_ALL  = 2'h0;
  localparam logic [1:0]  IRQ_LEVEL_MASK = 2'h3;
  // Byte counts.
  localparam logic [1:0]  LEN_NONE = 2'h0;
  localparam logic [1:0]  LEN_BYTE = 2'h1;
  localparam logic [1:0]  LEN_WORD = 2'h2;
  localparam logic [2:0]  OPC_LEN  = 3'h1;
  // Memory read phases: issue, memory samples, data valid.
  localparam logic [1:0]  PH_ISSUE = 2'h0;
  localparam logic [1:0]  PH_WAIT  = 2'h1;
  localparam logic [1:0]  PH_TAKE  = 2'h2;

  typedef enum logic [4:0] {
    M_INH, M_IMM, M_DIR_S, M_DIR_L, M_IDX_0, M_IDX_S, M_IDX_L,
    M_IND_S, M_IND_L, M_INDX_S, M_INDX_L, M_REL_D, M_REL_I,
    M_BIT_D, M_BIT_I, M_BITR_D, M_BITR_I
  } amd_mode_t;

  typedef enum logic [2:0] {
    G_INHERENT, G_IMMEDIATE, G_DIRECT, G_INDEXED, G_INDIRECT, G_RELATIVE, G_BIT
  } amd_group_t;
endpackage
`default_nettype wire

// ===== sim/amd_chk.sv
// Assertions on the decoder's ports.
// Assumes one clock domain with synchronous active-high reset.
`default_nettype none
module amd_chk (
  // Clock and reset.
  input wire logic                clk_sys,
  input wire logic                reset,
  // Watched ports.
  input wire logic                mem_rd_ff,
  input wire logic                exec_done,
  input wire logic                irq_req,
  input wire logic                wake_pin,
  input wire logic                dec_valid_ff,
  input wire logic [7:0]          dec_opcode_ff,
  input wire amd_pkg::amd_group_t dec_group_ff,
  input wire logic [2:0]          dec_len_ff,
  input wire logic                dec_use_y_ff,
  input wire logic [1:0]          irq_mask_ff,
  input wire logic                wait_ff,
  input wire logic                osc_stop_ff,
  input wire logic                stack_push_ff,
  input wire logic                stack_pop_ff,
  input wire logic [15:0]         sp_ff
);
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (reset);
  a_read_spacing: assert property (mem_rd_ff |=> !mem_rd_ff [*2])
    else $error("read pulses closer than three cycles");
  a_inh_one_byte: assert property (dec_valid_ff && dec_group_ff == amd_pkg::G_INHERENT
    |-> dec_len_ff == (dec_use_y_ff ? 3'h2 : 3'h1)) else $error("inherent length wrong");
  a_imm_two_bytes: assert property (dec_valid_ff && dec_group_ff == amd_pkg::G_IMMEDIATE
    |-> dec_len_ff == (dec_use_y_ff ? 3'h3 : 3'h2)) else $error("immediate length wrong");
  a_mask_raise: assert property (dec_valid_ff && dec_opcode_ff == amd_pkg::SET_IRQ_MASK_OP
    |-> ##[0:2] irq_mask_ff == 2'h3) else $error("mask not raised");
  a_mask_lower: assert property (dec_valid_ff && dec_opcode_ff == amd_pkg::CLEAR_IRQ_MASK_OP
    |-> ##[0:2] irq_mask_ff == 2'h0) else $error("mask not lowered");
  a_push_sp: assert property (stack_push_ff |-> sp_ff == $past(sp_ff) - 16'h0001)
    else $error("push did not step stack down");
  a_pop_sp: assert property (stack_pop_ff |-> sp_ff == $past(sp_ff) + 16'h0001)
    else $error("pop did not step stack up");
  a_wait_stays: assert property (wait_ff && !irq_req |=> wait_ff)
    else $error("wait left without interrupt");
  a_wait_ends: assert property (wait_ff && irq_req |-> ##[0:3] !wait_ff)
    else $error("wait not left on interrupt");
  a_halt_wakes: assert property ($rose(wake_pin) && osc_stop_ff |-> ##[1:8] !osc_stop_ff)
    else $error("halt not left on wake");
  a_halt_no_fetch: assert property (osc_stop_ff |-> !mem_rd_ff)
    else $error("fetch while halted");
  a_hold_decode: assert property (dec_valid_ff && !exec_done |=> !mem_rd_ff)
    else $error("fetch before execution done");
  c_push: cover property (stack_push_ff);
  c_wake: cover property (wait_ff && irq_req);
  c_second: cover property (dec_valid_ff && dec_use_y_ff);
endmodule
bind amd_decoder amd_chk u_chk (.*);
`default_nettype wire

// ===== sim/amd_mem_model.sv
// Byte memory that answers the decoder's read pulses.
// Assumes read pulses at least three cycles apart on the decoder's clock.
`default_nettype none
module amd_mem_model (
  // Clock.
  input  wire logic        clk_sys,
  // Read port.
  input  wire logic [15:0] mem_addr_ff,
  input  wire logic        mem_rd_ff,
  output var  logic [7:0]  mem_rdata
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [7:0] store [0:65535];
  logic [1:0] hold_ff;
  // Data stands for three edges after a pulse, then toggles so a late sample shows.
  always @(posedge clk_sys) begin
    if (mem_rd_ff) begin
      mem_rdata <= store[mem_addr_ff];
      hold_ff   <= 2'h2;
    end else if (hold_ff != 2'h0) begin
      hold_ff <= hold_ff - 2'h1;
    end else begin
      mem_rdata <= ~mem_rdata;
    end
  end
  initial begin
    mem_rdata = 8'h00;
    hold_ff   = 2'h0;
    foreach (store[i])
      store[i] = 8'h9D;
  end
endmodule
`default_nettype wire

// ===== sim/tb_top.sv
// Self-checking bench for the addressing-mode decoder.
// Assumes the memory model and the bound checker are compiled before it.
`default_nettype none
module tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  logic                clk_sys = 1'b0;
  logic                reset = 1'b1;
  logic [15:0]         mem_addr_ff;
  logic                mem_rd_ff;
  logic [7:0]          mem_rdata;
  logic [7:0]          index_x = 8'h00;
  logic [7:0]          index_y = 8'h00;
  logic                exec_done = 1'b0;
  logic                pc_load = 1'b0;
  logic [15:0]         pc_load_addr = 16'h0000;
  logic                irq_req = 1'b0;
  logic                wake_pin = 1'b0;
  logic                dec_valid_ff;
  logic [7:0]          dec_opcode_ff;
  amd_pkg::amd_mode_t  dec_mode_ff;
  amd_pkg::amd_group_t dec_group_ff;
  logic [2:0]          dec_len_ff;
  logic [7:0]          dec_operand_ff;
  logic [15:0]         dec_ea_ff, dec_target_ff, dec_next_pc_ff, sp_ff;
  logic                dec_use_y_ff, wait_ff, osc_stop_ff, stack_push_ff, stack_pop_ff;
  logic [1:0]          irq_mask_ff;
  int                  num_errors = 0;
  int                  samples_checked = 0;

  always #2 clk_sys = ~clk_sys;

  amd_decoder dut (.*);

  amd_mem_model mem (.*);

  ////////////////////////////////////////////////////////////////////////////
  task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
    samples_checked++;
    if (got !== exp) begin
      num_errors++;
      $display("wrong value %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic close_out();
    $display("checked %0d mismatches %0d", samples_checked, num_errors);
    if (num_errors == 0 && samples_checked > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask

  // Fields are read at the edge that ends the decode-valid cycle.
  task automatic wait_dec();
    int k;
    k = 0;
    while (dec_valid_ff !== 1'b1 && k < 80) begin
      @(posedge clk_sys);
      k++;
    end
    chk("decode done", 16'h1, dec_valid_ff);
  endtask

  // Finishes the current instruction, jumps to a and decodes n bytes placed there.
  task automatic go(input logic [15:0] a, input logic [31:0] w, input int n);
    for (int i = 0; i < n; i++)
      mem.store[a + i] = w[31 - 8 * i -: 8];
    @(posedge clk_sys);
    exec_done    <= 1'b1;
    pc_load      <= 1'b1;
    pc_load_addr <= a;
    @(posedge clk_sys);
    exec_done <= 1'b0;
    pc_load   <= 1'b0;
    wait_dec();
  endtask

  task automatic dec(input amd_pkg::amd_mode_t m, input amd_pkg::amd_group_t g,
                     input logic [2:0] l);
    chk("mode", m, dec_mode_ff);
    chk("group", g, dec_group_ff);
    chk("length", l, dec_len_ff);
  endtask

  ////////////////////////////////////////////////////////////////////////////
  task automatic t_reset();
    @(posedge clk_sys);
    chk("mask", 16'h0003, irq_mask_ff);
    chk("sp", 16'h01FF, sp_ff);
    wait_dec();
    dec(amd_pkg::M_INH, amd_pkg::G_INHERENT, 3'h1);
    chk("next pc", 16'h0001, dec_next_pc_ff);
  endtask

  task automatic t_imm_dir();
    go(16'h0100, 32'hA6550000, 2);
    dec(amd_pkg::M_IMM, amd_pkg::G_IMMEDIATE, 3'h2);
    chk("operand", 16'h0055, dec_operand_ff);
    chk("next pc", 16'h0102, dec_next_pc_ff);
    go(16'h0200, 32'hB6100000, 2);
    dec(amd_pkg::M_DIR_S, amd_pkg::G_DIRECT, 3'h2);
    chk("ea", 16'h0010, dec_ea_ff);
    go(16'h0210, 32'hC6123400, 3);
    dec(amd_pkg::M_DIR_L, amd_pkg::G_DIRECT, 3'h3);
    chk("ea", 16'h1234, dec_ea_ff);
  endtask

  task automatic t_index();
    index_x <= 8'hFF;
    index_y <= 8'h22;
    go(16'h0300, 32'hE6FF0000, 2);
    dec(amd_pkg::M_IDX_S, amd_pkg::G_INDEXED, 3'h2);
    chk("ea", 16'h01FE, dec_ea_ff);
    go(16'h0310, 32'hF6000000, 1);
    dec(amd_pkg::M_IDX_0, amd_pkg::G_INDEXED, 3'h1);
    chk("ea", 16'h00FF, dec_ea_ff);
    go(16'h0320, 32'h90D61234, 4);
    dec(amd_pkg::M_IDX_L, amd_pkg::G_INDEXED, 3'h4);
    chk("ea", 16'h1256, dec_ea_ff);
    chk("use y", 16'h0001, dec_use_y_ff);
  endtask

  task automatic t_indirect();
    mem.store[16'h0020] = 8'hAB;
    mem.store[16'h0021] = 8'hCD;
    go(16'h0400, 32'h92B62000, 3);
    dec(amd_pkg::M_IND_S, amd_pkg::G_INDIRECT, 3'h3);
    chk("ea", 16'h00AB, dec_ea_ff);
    go(16'h0410, 32'h92C62000, 3);
    dec(amd_pkg::M_IND_L, amd_pkg::G_INDIRECT, 3'h3);
    chk("ea", 16'hABCD, dec_ea_ff);
    go(16'h0420, 32'h92E62000, 3);
    dec(amd_pkg::M_INDX_S, amd_pkg::G_INDIRECT, 3'h3);
    chk("ea", 16'h01AA, dec_ea_ff);
    go(16'h0430, 32'h923C2000, 3);
    dec(amd_pkg::M_IND_S, amd_pkg::G_INDIRECT, 3'h3);
    go(16'h0440, 32'h3C200000, 2);
    dec(amd_pkg::M_DIR_S, amd_pkg::G_DIRECT, 3'h2);
    chk("ea", 16'h0020, dec_ea_ff);
  endtask

  task automatic t_rel_bit();
    go(16'h0500, 32'h20FE0000, 2);
    dec(amd_pkg::M_REL_D, amd_pkg::G_RELATIVE, 3'h2);
    chk("target", 16'h0500, dec_target_ff);
    go(16'h0510, 32'h207F0000, 2);
    chk("target", 16'h0591, dec_target_ff);
    go(16'h0520, 32'h00100500, 3);
    dec(amd_pkg::M_BITR_D, amd_pkg::G_BIT, 3'h3);
    chk("target", 16'h0528, dec_target_ff);
    go(16'h0530, 32'h10100000, 2);
    dec(amd_pkg::M_BIT_D, amd_pkg::G_BIT, 3'h2);
    go(16'h0540, 32'h92202000, 3);
    dec(amd_pkg::M_REL_I, amd_pkg::G_RELATIVE, 3'h3);
    chk("target", 16'h04EE, dec_target_ff);
  endtask

  task automatic t_ctrl();
    go(16'h0600, 32'h9A000000, 1);
    repeat (2) @(posedge clk_sys);
    chk("mask", 16'h0000, irq_mask_ff);
    go(16'h0601, 32'h9B000000, 1);
    repeat (2) @(posedge clk_sys);
    chk("mask", 16'h0003, irq_mask_ff);
    go(16'h0602, 32'h88000000, 1);
    chk("push", 16'h0001, stack_push_ff);
    chk("sp", 16'h01FE, sp_ff);
    go(16'h0603, 32'h84000000, 1);
    chk("pop", 16'h0001, stack_pop_ff);
    chk("sp", 16'h01FF, sp_ff);
    go(16'h0604, 32'h88000000, 1);
    go(16'h0605, 32'h9C000000, 1);
    repeat (2) @(posedge clk_sys);
    chk("sp", 16'h01FF, sp_ff);
    go(16'h0606, 32'h4D000000, 1);
    dec(amd_pkg::M_INH, amd_pkg::G_INHERENT, 3'h1);
    go(16'h0607, 32'h48000000, 1);
    dec(amd_pkg::M_INH, amd_pkg::G_INHERENT, 3'h1);
  endtask

  task automatic t_low_power();
    go(16'h0700, 32'h8F000000, 1);
    chk("wait", 16'h0001, wait_ff);
    exec_done <= 1'b1;
    @(posedge clk_sys);
    exec_done <= 1'b0;
    repeat (6) @(posedge clk_sys);
    chk("wait", 16'h0001, wait_ff);
    chk("read addr", 16'h0700, mem_addr_ff);
    irq_req <= 1'b1;
    for (int k = 0; k < 8 && wait_ff !== 1'b0; k++)
      @(posedge clk_sys);
    chk("wait", 16'h0000, wait_ff);
    irq_req <= 1'b0;
    go(16'h0710, 32'h8E000000, 1);
    repeat (5) @(posedge clk_sys);
    chk("halt", 16'h0001, osc_stop_ff);
    chk("read addr", 16'h0710, mem_addr_ff);
    wake_pin <= 1'b1;
    for (int k = 0; k < 12 && osc_stop_ff !== 1'b0; k++)
      @(posedge clk_sys);
    chk("halt", 16'h0000, osc_stop_ff);
    wake_pin <= 1'b0;
    go(16'h0720, 32'h9D000000, 1);
    dec(amd_pkg::M_INH, amd_pkg::G_INHERENT, 3'h1);
  endtask

  ////////////////////////////////////////////////////////////////////////////
  initial begin
    repeat (10) @(posedge clk_sys);
    reset <= 1'b0;
    t_reset();
    t_imm_dir();
    t_index();
    t_indirect();
    t_rel_bit();
    t_ctrl();
    t_low_power();
    close_out();
  end

  initial begin
    repeat (20000) @(posedge clk_sys);
    num_errors++;
    $display("wrong value watchdog expected done seen hang");
    close_out();
  end
endmodule
`default_nettype wire
